//--- core/otw_pkg.sv
// shared constants for the text window writer
package otw_pkg;

	// ************************************************************
	// register map (byte subaddresses)
	// ************************************************************
	localparam logic [7:0] MASK_ADDR  = 8'h00;
	localparam logic [7:0] PROP2_ADDR = 8'h01;
	localparam logic [7:0] PROP1_ADDR = 8'h02;
	localparam logic [7:0] PROP0_ADDR = 8'h03;
	localparam logic [7:0] CURX_ADDR  = 8'h04;
	localparam logic [7:0] CURY_ADDR  = 8'h05;
	localparam logic [7:0] CTRL0_ADDR = 8'h06;
	localparam logic [7:0] FAULX_ADDR = 8'h07;
	localparam logic [7:0] FAULY_ADDR = 8'h08;
	localparam logic [7:0] FABRX_ADDR = 8'h09;
	localparam logic [7:0] FABRY_ADDR = 8'h0a;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int BLINK_MASK_BIT  = 7;
	localparam int SHADOW_MASK_BIT = 6;
	localparam int BACKGROUND_UPDATE_ENABLE_BIT     = 5;
	localparam int FOREGROUND_UPDATE_ENABLE_BIT     = 4;
	localparam int CODE_MASK_BIT   = 3;
	localparam int MODE_MSB        = 2;
	localparam int FILL_START_BIT  = 0;
	localparam logic [7:0] MASK_RESET  = 8'hf8;
	localparam logic [7:0] PROP_RESET  = 8'h00;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic [6:0] PROP2_USED  = 7'h7f;

	// ************************************************************
	// element layout, 23 bits
	// ************************************************************
	localparam int ELEM_W = 23;
	localparam logic [22:0] BLINK_BITS  = 23'h600000;
	localparam logic [22:0] SHADOW_BITS = 23'h100000;
	localparam logic [22:0] BG_BITS     = 23'h0ae000;
	localparam logic [22:0] FG_BITS     = 23'h051c00;
	localparam logic [22:0] CODE_BITS   = 23'h0003ff;

	// ************************************************************
	// window geometry defaults
	// ************************************************************
	localparam int COL_W    = 8;
	localparam int ROW_W    = 8;
	localparam int COLS_DEF = 64;
	localparam int ROWS_DEF = 32;

endpackage

//--- core/otw_ram_if.sv
// write port bundle between the writer and its window memory
`timescale 1ns/100ps
interface otw_ram_if #(
	parameter int AW = 11
);
	logic                       we;
	logic [AW-1:0]              addr;
	logic [otw_pkg::ELEM_W-1:0] wdata;
	logic [otw_pkg::ELEM_W-1:0] wmask;

	modport writer (output we, output addr, output wdata, output wmask);
	modport memory (input we, input addr, input wdata, input wmask);
endinterface

//--- core/otw_window_ram.sv
// window element memory with per-bit write mask and registered read
`timescale 1ns/100ps
module otw_window_ram #(
	parameter int AW    = 11,
	parameter int DEPTH = 2048
) (
	input  wire logic                       ref_clk_i,
	otw_ram_if.memory                       wr,
	input  wire logic [AW-1:0]              rd_addr_i,
	output logic      [otw_pkg::ELEM_W-1:0] rd_data_o
);
	logic [otw_pkg::ELEM_W-1:0] mem [DEPTH];

	// masked-out bits keep the stored value
	always_ff @(posedge ref_clk_i) begin
		if (wr.we) begin
			mem[wr.addr] <= (mem[wr.addr] & ~wr.wmask)
				| (wr.wdata & wr.wmask);
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

//--- core/otw_fill_seq.sv
// rectangle walker for the area fill, one element per cycle
`timescale 1ns/100ps
module otw_fill_seq #(
	parameter int CW = 8,
	parameter int RW = 8
) (
	input  wire logic          ref_clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          start_i,
	input  wire logic [CW-1:0] left_i,
	input  wire logic [RW-1:0] top_i,
	input  wire logic [CW-1:0] right_i,
	input  wire logic [RW-1:0] bottom_i,
	output logic               busy_o,
	output logic               valid_o,
	output logic [CW-1:0]      col_o,
	output logic [RW-1:0]      row_o,
	output logic               done_o
);
	logic          next_busy;
	logic [CW-1:0] next_col;
	logic [RW-1:0] next_row;
	logic          next_done;

	// an inverted rectangle writes nothing and finishes at once
	always_comb begin
		next_busy = busy_o;
		next_col  = col_o;
		next_row  = row_o;
		next_done = 1'b0;
		if (!busy_o) begin
			if (start_i) begin
				if (right_i < left_i || bottom_i < top_i) begin
					next_done = 1'b1;
				end else begin
					next_busy = 1'b1;
					next_col  = left_i;
					next_row  = top_i;
				end
			end
		end else if (col_o != right_i) begin
			next_col = col_o + 1'b1;
		end else if (row_o != bottom_i) begin
			next_col = left_i;
			next_row = row_o + 1'b1;
		end else begin
			next_busy = 1'b0;
			next_done = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			col_o  <= '0;
			row_o  <= '0;
			done_o <= 1'b0;
		end else begin
			busy_o <= next_busy;
			col_o  <= next_col;
			row_o  <= next_row;
			done_o <= next_done;
		end
	end

	assign valid_o = busy_o;
endmodule

//--- core/otw_text_window_writer.sv
// text window write path: property registers, commit, cursor, fill
//
// Overview of operation
// - an element is committed and the cursor moved only after every register enabled by the commit-select field got a fresh write.
// - registers not enabled by commit-select still contribute their held value to each committed element.
// - codes 001, 010, 100 enable one register, bursts stay on it and each byte commits one element.
// - multi-register codes make bursts walk enabled registers high to low and wrap, committing after the lowest.
// - code 000 enables none, so property writes never commit nor move the cursor.
// - a burst after one subaddress streams successive property values for consecutive elements.
// - each element attribute is only overwritten when its mask bit is 1, else the stored value stays.
// - the mask register holds blink, shadow, background, foreground, code masks at D7..D3 and commit-select at D2..D0.
// - the background mask gates background transparency, alpha and colour index together.
// - the foreground mask gates foreground transparency, alpha and colour or palette index together.
// - the code mask gates the font select flag and the full nine-bit character index together.
// - four coordinate registers hold the upper-left and bottom-right corners of the fill rectangle.
// - writing 1 to the fill start bit writes the masked property word into every element of the rectangle.
// - the fill applies the same attribute masks as single element writes.
// - after each commit the cursor moves right or to the next line start, and it is readable anytime.
// - each element stores 23 bits of blink, shadow, flags, colour indices, font select and code.
`timescale 1ns/100ps
module otw_text_window_writer #(
	parameter int COLS = otw_pkg::COLS_DEF,
	parameter int ROWS = otw_pkg::ROWS_DEF
) (
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         sub_load_i,
	input  wire logic [7:0]                   sub_addr_i,
	input  wire logic                         wr_en_i,
	input  wire logic [7:0]                   wr_data_i,
	input  wire logic                         rd_en_i,
	output logic      [7:0]                   rd_data_o,
	input  wire logic [$clog2(COLS*ROWS)-1:0] disp_addr_i,
	output logic      [otw_pkg::ELEM_W-1:0]   disp_data_o,
	output logic                              fill_busy_o
);
	localparam int DEPTH = COLS * ROWS;
	localparam int AW    = $clog2(DEPTH);
	localparam int CW    = otw_pkg::COL_W;
	localparam int RW    = otw_pkg::ROW_W;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [AW-1:0] elem_addr(input logic [CW-1:0] c,
		input logic [RW-1:0] r);
		elem_addr = AW'(int'(r) * COLS + int'(c));
	endfunction

	// write mask from the attribute mask bits
	function automatic logic [22:0] attr_mask(input logic [7:0] m);
		attr_mask = '0;
		if (m[otw_pkg::BLINK_MASK_BIT])  attr_mask |= otw_pkg::BLINK_BITS;
		if (m[otw_pkg::SHADOW_MASK_BIT]) attr_mask |= otw_pkg::SHADOW_BITS;
		if (m[otw_pkg::BACKGROUND_UPDATE_ENABLE_BIT])     attr_mask |= otw_pkg::BG_BITS;
		if (m[otw_pkg::FOREGROUND_UPDATE_ENABLE_BIT])     attr_mask |= otw_pkg::FG_BITS;
		if (m[otw_pkg::CODE_MASK_BIT])   attr_mask |= otw_pkg::CODE_BITS;
	endfunction

	// property register index 2..0 of a subaddress, 3 if none
	function automatic logic [1:0] prop_idx(input logic [7:0] a);
		if (a == otw_pkg::PROP2_ADDR) begin
			prop_idx = 2'd2;
		end else if (a == otw_pkg::PROP1_ADDR) begin
			prop_idx = 2'd1;
		end else if (a == otw_pkg::PROP0_ADDR) begin
			prop_idx = 2'd0;
		end else begin
			prop_idx = 2'd3;
		end
	endfunction

	function automatic logic [7:0] prop_addr(input logic [1:0] k);
		case (k)
			2'd2:    prop_addr = otw_pkg::PROP2_ADDR;
			2'd1:    prop_addr = otw_pkg::PROP1_ADDR;
			default: prop_addr = otw_pkg::PROP0_ADDR;
		endcase
	endfunction

	// next subaddress of a burst
	function automatic logic [7:0] next_sub(input logic [7:0] a,
		input logic [2:0] mode);
		logic [1:0] k;
		logic [1:0] top;
		k   = prop_idx(a);
		top = mode[2] ? 2'd2 : (mode[1] ? 2'd1 : 2'd0);
		if (k == 2'd3 || !mode[k]) begin
			next_sub = a + 8'h01;
		end else if (k == 2'd2 && mode[1]) begin
			next_sub = otw_pkg::PROP1_ADDR;
		end else if (k != 2'd0 && mode[0]) begin
			next_sub = otw_pkg::PROP0_ADDR;
		end else begin
			next_sub = prop_addr(top);
		end
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0]    sub_ptr;
	logic [7:0]    mask_ctl;
	logic [7:0]    prop_high;
	logic [7:0]    prop_mid;
	logic [7:0]    prop_low;
	logic [2:0]    pend;
	logic [CW-1:0] cursor_column;
	logic [RW-1:0] cursor_row;
	logic          fill_start;
	logic [CW-1:0] rect_left_column;
	logic [RW-1:0] rect_top_row;
	logic [CW-1:0] rect_right_column;
	logic [RW-1:0] rect_bottom_row;
	logic          ram_we;
	logic [AW-1:0] ram_addr;
	logic [22:0]   ram_wdata;
	logic [22:0]   ram_wmask;

	logic [7:0]    next_sub_ptr;
	logic [7:0]    next_mask_ctl;
	logic [7:0]    next_prop_high;
	logic [7:0]    next_prop_mid;
	logic [7:0]    next_prop_low;
	logic [2:0]    next_pend;
	logic [CW-1:0] next_cursor_column;
	logic [RW-1:0] next_cursor_row;
	logic          next_fill_start;
	logic [CW-1:0] next_rect_left_column;
	logic [RW-1:0] next_rect_top_row;
	logic [CW-1:0] next_rect_right_column;
	logic [RW-1:0] next_rect_bottom_row;
	logic          next_ram_we;
	logic [AW-1:0] next_ram_addr;
	logic [22:0]   next_ram_wdata;
	logic [22:0]   next_ram_wmask;
	logic [7:0]    next_rd_data;
	logic          fill_go;
	logic          fill_valid;
	logic          fill_done;
	logic [CW-1:0] fill_col;
	logic [RW-1:0] fill_row;

	// ************************************************************
	// submodules
	// ************************************************************
	otw_ram_if #(.AW(AW)) ram_bus ();
	assign ram_bus.we    = ram_we;
	assign ram_bus.addr  = ram_addr;
	assign ram_bus.wdata = ram_wdata;
	assign ram_bus.wmask = ram_wmask;

	otw_window_ram #(.AW(AW), .DEPTH(DEPTH)) u_ram (
		.ref_clk_i (ref_clk_i),
		.wr        (ram_bus),
		.rd_addr_i (disp_addr_i),
		.rd_data_o (disp_data_o)
	);

	// start is seen once: the bit stays set until done clears it
	assign fill_go = fill_start && !fill_busy_o && !fill_done;

	otw_fill_seq #(.CW(CW), .RW(RW)) u_fill (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (fill_go),
		.left_i    (rect_left_column),
		.top_i     (rect_top_row),
		.right_i   (rect_right_column),
		.bottom_i  (rect_bottom_row),
		.busy_o    (fill_busy_o),
		.valid_o   (fill_valid),
		.col_o     (fill_col),
		.row_o     (fill_row),
		.done_o    (fill_done)
	);

	// ************************************************************
	// register writes, commit and cursor
	// ************************************************************
	always_comb begin
		logic [7:0]  wa;
		logic [1:0]  k;
		logic [2:0]  mode;
		logic [2:0]  p;
		logic        commit;
		wa     = sub_load_i ? sub_addr_i : sub_ptr;
		k      = prop_idx(wa);
		mode   = mask_ctl[otw_pkg::MODE_MSB:0];
		p      = pend;
		commit = 1'b0;
		next_sub_ptr           = sub_load_i ? sub_addr_i : sub_ptr;
		next_mask_ctl          = mask_ctl;
		next_prop_high         = prop_high;
		next_prop_mid          = prop_mid;
		next_prop_low          = prop_low;
		next_cursor_column     = cursor_column;
		next_cursor_row        = cursor_row;
		next_fill_start        = fill_start && !fill_done;
		next_rect_left_column  = rect_left_column;
		next_rect_top_row      = rect_top_row;
		next_rect_right_column = rect_right_column;
		next_rect_bottom_row   = rect_bottom_row;
		if (wr_en_i) begin
			next_sub_ptr = next_sub(wa, mode);
			if (wa == otw_pkg::MASK_ADDR) begin
				next_mask_ctl = wr_data_i;
				p             = 3'b000;
			end else if (wa == otw_pkg::PROP2_ADDR) begin
				next_prop_high = wr_data_i & {1'b0, otw_pkg::PROP2_USED};
			end else if (wa == otw_pkg::PROP1_ADDR) begin
				next_prop_mid = wr_data_i;
			end else if (wa == otw_pkg::PROP0_ADDR) begin
				next_prop_low = wr_data_i;
			end else if (wa == otw_pkg::CURX_ADDR) begin
				next_cursor_column = wr_data_i[CW-1:0];
			end else if (wa == otw_pkg::CURY_ADDR) begin
				next_cursor_row = wr_data_i[RW-1:0];
			end else if (wa == otw_pkg::CTRL0_ADDR) begin
				if (wr_data_i[otw_pkg::FILL_START_BIT]) begin
					next_fill_start = 1'b1;
				end
			end else if (wa == otw_pkg::FAULX_ADDR) begin
				next_rect_left_column = wr_data_i[CW-1:0];
			end else if (wa == otw_pkg::FAULY_ADDR) begin
				next_rect_top_row = wr_data_i[RW-1:0];
			end else if (wa == otw_pkg::FABRX_ADDR) begin
				next_rect_right_column = wr_data_i[CW-1:0];
			end else if (wa == otw_pkg::FABRY_ADDR) begin
				next_rect_bottom_row = wr_data_i[RW-1:0];
			end
			// mode 000 never completes; fills block commits
			if (k != 2'd3 && mode[k] && !fill_busy_o && !fill_start) begin
				p = p | (3'b001 << k);
				if ((p & mode) == mode) begin
					commit = 1'b1;
					p      = 3'b000;
				end
			end
		end
		next_pend = p;
		// inactive registers keep their held value in the word
		next_ram_wdata = {next_prop_high[6:0], next_prop_mid, next_prop_low};
		next_ram_wmask = attr_mask(mask_ctl);
		next_ram_we    = commit || fill_valid;
		next_ram_addr  = elem_addr(cursor_column, cursor_row);
		if (fill_valid) begin
			next_ram_wdata = {prop_high[6:0], prop_mid, prop_low};
			next_ram_addr  = elem_addr(fill_col, fill_row);
		end
		if (commit) begin
			if (int'(cursor_column) == COLS - 1) begin
				next_cursor_column = '0;
				next_cursor_row    = (int'(cursor_row) == ROWS - 1) ?
					'0 : cursor_row + 1'b1;
			end else begin
				next_cursor_column = cursor_column + 1'b1;
			end
		end
	end

	// ************************************************************
	// read path, cursor always visible
	// ************************************************************
	always_comb begin
		next_rd_data = rd_data_o;
		if (rd_en_i) begin
			if (sub_ptr == otw_pkg::MASK_ADDR) begin
				next_rd_data = mask_ctl;
			end else if (sub_ptr == otw_pkg::PROP2_ADDR) begin
				next_rd_data = prop_high;
			end else if (sub_ptr == otw_pkg::PROP1_ADDR) begin
				next_rd_data = prop_mid;
			end else if (sub_ptr == otw_pkg::PROP0_ADDR) begin
				next_rd_data = prop_low;
			end else if (sub_ptr == otw_pkg::CURX_ADDR) begin
				next_rd_data = 8'(cursor_column);
			end else if (sub_ptr == otw_pkg::CURY_ADDR) begin
				next_rd_data = 8'(cursor_row);
			end else if (sub_ptr == otw_pkg::CTRL0_ADDR) begin
				next_rd_data = {7'h00, fill_start};
			end else if (sub_ptr == otw_pkg::FAULX_ADDR) begin
				next_rd_data = 8'(rect_left_column);
			end else if (sub_ptr == otw_pkg::FAULY_ADDR) begin
				next_rd_data = 8'(rect_top_row);
			end else if (sub_ptr == otw_pkg::FABRX_ADDR) begin
				next_rd_data = 8'(rect_right_column);
			end else if (sub_ptr == otw_pkg::FABRY_ADDR) begin
				next_rd_data = 8'(rect_bottom_row);
			end else begin
				next_rd_data = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sub_ptr           <= 8'h00;
			mask_ctl          <= otw_pkg::MASK_RESET;
			prop_high         <= otw_pkg::PROP_RESET;
			prop_mid          <= otw_pkg::PROP_RESET;
			prop_low          <= otw_pkg::PROP_RESET;
			pend              <= 3'b000;
			cursor_column     <= '0;
			cursor_row        <= '0;
			fill_start        <= otw_pkg::CTRL0_RESET[0];
			rect_left_column  <= '0;
			rect_top_row      <= '0;
			rect_right_column <= '0;
			rect_bottom_row   <= '0;
			ram_we            <= 1'b0;
			ram_addr          <= '0;
			ram_wdata         <= '0;
			ram_wmask         <= '0;
			rd_data_o         <= 8'h00;
		end else begin
			sub_ptr           <= rd_en_i && !wr_en_i ?
				sub_ptr + 8'h01 : next_sub_ptr;
			mask_ctl          <= next_mask_ctl;
			prop_high         <= next_prop_high;
			prop_mid          <= next_prop_mid;
			prop_low          <= next_prop_low;
			pend              <= next_pend;
			cursor_column     <= next_cursor_column;
			cursor_row        <= next_cursor_row;
			fill_start        <= next_fill_start;
			rect_left_column  <= next_rect_left_column;
			rect_top_row      <= next_rect_top_row;
			rect_right_column <= next_rect_right_column;
			rect_bottom_row   <= next_rect_bottom_row;
			ram_we            <= next_ram_we;
			ram_addr          <= next_ram_addr;
			ram_wdata         <= next_ram_wdata;
			ram_wmask         <= next_ram_wmask;
			rd_data_o         <= next_rd_data;
		end
	end
endmodule

//--- dv/otw_host_model.sv
// host side register access model for the text window writer
`timescale 1ns/100ps
module otw_host_model (
	input  wire logic       ref_clk_i,
	output logic            sub_load_o,
	output logic [7:0]      sub_addr_o,
	output logic            wr_en_o,
	output logic [7:0]      wr_data_o,
	output logic            rd_en_o,
	input  wire logic [7:0] rd_data_i
);
	initial begin
		sub_load_o = 1'b0;
		sub_addr_o = 8'h00;
		wr_en_o    = 1'b0;
		wr_data_o  = 8'h00;
		rd_en_o    = 1'b0;
	end

	// ld low streams on without a subaddress; the unused line shows junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic ld);
		sub_load_o = ld;
		sub_addr_o = ld ? a : ~sub_addr_o;
		wr_en_o    = 1'b1;
		rd_en_o    = 1'b0;
		wr_data_o  = d;
		@(posedge ref_clk_i);
		#1;
	endtask

	// address is loaded a cycle ahead, a read on the load reads stale
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sub_load_o = 1'b1;
		sub_addr_o = a;
		wr_en_o    = 1'b0;
		wr_data_o  = ~wr_data_o;
		@(posedge ref_clk_i);
		#1;
		sub_load_o = 1'b0;
		sub_addr_o = ~a;
		rd_en_o    = 1'b1;
		@(posedge ref_clk_i);
		#1;
		rd_en_o = 1'b0;
		d       = rd_data_i;
	endtask

	task automatic idle();
		sub_load_o = 1'b0;
		wr_en_o    = 1'b0;
		rd_en_o    = 1'b0;
		wr_data_o  = ~wr_data_o;
		@(posedge ref_clk_i);
		#1;
	endtask
endmodule

//--- dv/otw_checker_properties.sv
// port level properties of the text window writer
`timescale 1ns/100ps
module otw_checker #(
	parameter int COLS = 64,
	parameter int ROWS = 32,
	parameter int AW   = 11
) (
	input wire logic          ref_clk_i,
	input wire logic          rst_n_i,
	input wire logic          sub_load_i,
	input wire logic [7:0]    sub_addr_i,
	input wire logic          wr_en_i,
	input wire logic [7:0]    wr_data_i,
	input wire logic          rd_en_i,
	input wire logic [7:0]    rd_data_o,
	input wire logic [AW-1:0] disp_addr_i,
	input wire logic [22:0]   disp_data_o,
	input wire logic          fill_busy_o
);
	logic        start_wr;
	logic [15:0] busy_cnt;
	logic [15:0] next_busy_cnt;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	assign start_wr = sub_load_i && wr_en_i && wr_data_i[0] &&
		sub_addr_i == otw_pkg::CTRL0_ADDR;

	// a fill never walks longer than the whole window
	always_comb begin
		next_busy_cnt = fill_busy_o ? busy_cnt + 16'h0001 : 16'h0000;
		if (!rst_n_i) begin
			next_busy_cnt = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		busy_cnt <= next_busy_cnt;
	end

	fill_launch_a: assert property (start_wr && !fill_busy_o
		|-> ##2 fill_busy_o)
		else $error("fill did not start two cycles after start write");
	busy_cause_a: assert property ($rose(fill_busy_o)
		|-> $past(start_wr, 2))
		else $error("fill started without a start write");
	fill_bound_a: assert property (int'(busy_cnt) <= COLS*ROWS + 1)
		else $error("fill busy longer than the window");
	rd_hold_a: assert property (!rd_en_i |=> $stable(rd_data_o))
		else $error("read data changed without a read");
	mask_echo_a: assert property (sub_load_i && wr_en_i &&
		sub_addr_i == otw_pkg::MASK_ADDR ##1 sub_load_i && !wr_en_i &&
		!rd_en_i && sub_addr_i == otw_pkg::MASK_ADDR ##1
		rd_en_i && !sub_load_i |=> rd_data_o == $past(wr_data_i, 3))
		else $error("mask register readback differs");
	prop_msb_a: assert property (sub_load_i && !wr_en_i && !rd_en_i &&
		sub_addr_i == otw_pkg::PROP2_ADDR ##1 rd_en_i && !sub_load_i
		|=> !rd_data_o[7])
		else $error("unused top property bit reads one");
	unmapped_zero_a: assert property (sub_load_i && !wr_en_i &&
		!rd_en_i && sub_addr_i > 8'h0a ##1 rd_en_i && !sub_load_i
		|=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	start_seen_a: assert property (sub_load_i && !wr_en_i && !rd_en_i &&
		sub_addr_i == otw_pkg::CTRL0_ADDR ##1 rd_en_i && !sub_load_i &&
		fill_busy_o |=> rd_data_o[0])
		else $error("start bit low during fill");
endmodule

//--- dv/tb.sv
// self-checking bench for the text window writer
`timescale 1ns/100ps
module tb;
	localparam int COLS = 8;
	localparam int ROWS = 4;
	localparam int N    = COLS*ROWS;
	localparam logic [7:0] MK [12] = '{8'hf9, 8'hfb, 8'hfa, 8'hfc, 8'hfd,
		8'hfe, 8'hff, 8'h87, 8'h47, 8'h27, 8'h17, 8'h0f};
	localparam int NE [12] = '{3, 2, 2, 2, 1, 1, 2, 1, 1, 1, 1, 1};

	logic        ref_clk_i;
	logic        rst_n_i;
	logic        sub_load;
	logic [7:0]  sub_addr;
	logic        wr_en;
	logic [7:0]  wr_data;
	logic        rd_en;
	logic [7:0]  rd_data;
	logic [4:0]  disp_addr;
	logic [22:0] disp_data;
	logic        fill_busy;
	logic [22:0] win [N];
	logic [22:0] prop;
	logic [7:0]  mask;
	logic [7:0]  d;
	int          cur;
	int          miscompares;
	int          num_checks;

	otw_text_window_writer #(.COLS(COLS), .ROWS(ROWS))
		otw_text_window_writer_i (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sub_load_i(sub_load),
		.sub_addr_i(sub_addr), .wr_en_i(wr_en), .wr_data_i(wr_data),
		.rd_en_i(rd_en), .rd_data_o(rd_data), .disp_addr_i(disp_addr),
		.disp_data_o(disp_data), .fill_busy_o(fill_busy));

	otw_host_model otw_host_model_i (.ref_clk_i(ref_clk_i),
		.sub_load_o(sub_load), .sub_addr_o(sub_addr), .wr_en_o(wr_en),
		.wr_data_o(wr_data), .rd_en_o(rd_en), .rd_data_i(rd_data));

	initial ref_clk_i = 1'b0;
	always #10 ref_clk_i = ~ref_clk_i;

	task automatic give_verdict();
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk23(input logic [22:0] got, input logic [22:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [7:0] v, input logic ld);
		otw_host_model_i.wr(a, v, ld);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		otw_host_model_i.rd(a, d);
		chk8(d, exp);
	endtask

	// masked merge of the held property word into the model window
	task automatic upd(input int i);
		logic [22:0] g;
		g = (mask[7] ? otw_pkg::BLINK_BITS : 23'h0) |
			(mask[6] ? otw_pkg::SHADOW_BITS : 23'h0) |
			(mask[5] ? otw_pkg::BG_BITS : 23'h0) |
			(mask[4] ? otw_pkg::FG_BITS : 23'h0) |
			(mask[3] ? otw_pkg::CODE_BITS : 23'h0);
		win[i] = (win[i] & ~g) | (prop & g);
	endtask

	task automatic check_all();
		repeat (3) @(posedge ref_clk_i);
		#1;
		for (int i = 0; i < N; i++) begin
			disp_addr = 5'(i);
			@(posedge ref_clk_i);
			#1;
			chk23(disp_data, win[i]);
		end
		rc(otw_pkg::CURX_ADDR, 8'(cur % COLS));
		rc(otw_pkg::CURY_ADDR, 8'(cur / COLS));
	endtask

	task automatic put(input logic [7:0] m, input logic [22:0] base,
		input int n);
		logic [22:0] v;
		logic        ld;
		w(otw_pkg::MASK_ADDR, m, 1'b1);
		mask = m;
		ld   = 1'b1;
		for (int i = 0; i < n; i++) begin
			v = base + 23'(i) * 23'h010203;
			if (m[2]) begin
				w(otw_pkg::PROP2_ADDR, {1'b0, v[22:16]}, ld);
				prop[22:16] = v[22:16];
				ld = 1'b0;
			end
			if (m[1]) begin
				w(otw_pkg::PROP1_ADDR, v[15:8], ld);
				prop[15:8] = v[15:8];
				ld = 1'b0;
			end
			if (m[0]) begin
				w(otw_pkg::PROP0_ADDR, v[7:0], ld);
				prop[7:0] = v[7:0];
				ld = 1'b0;
			end
			upd(cur);
			cur = (cur + 1) % N;
		end
		otw_host_model_i.idle();
	endtask

	task automatic fill(input logic [7:0] l, input logic [7:0] t,
		input logic [7:0] rr, input logic [7:0] b);
		int k;
		w(otw_pkg::FAULX_ADDR, l, 1'b1);
		w(otw_pkg::FAULY_ADDR, t, 1'b0);
		w(otw_pkg::FABRX_ADDR, rr, 1'b0);
		w(otw_pkg::FABRY_ADDR, b, 1'b0);
		w(otw_pkg::CTRL0_ADDR, 8'h01, 1'b1);
		otw_host_model_i.rd(otw_pkg::CTRL0_ADDR, d);
		chk8(d & 8'h01, 8'h01);
		for (k = 0; k < 200 && fill_busy !== 1'b0; k++) begin
			@(posedge ref_clk_i);
			#1;
		end
		if (k == 200) begin
			miscompares++;
			give_verdict();
		end
		for (int y = t; y <= b; y++)
			for (int x = l; x <= rr; x++)
				upd(y*COLS + x);
		repeat (2) @(posedge ref_clk_i);
		#1;
		rc(otw_pkg::CTRL0_ADDR, 8'h00);
		check_all();
	endtask

	initial begin
		rst_n_i     = 1'b0;
		disp_addr   = 5'h00;
		cur         = 0;
		miscompares = 0;
		num_checks  = 0;
		mask        = 8'hf8;
		repeat (10) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		rc(otw_pkg::MASK_ADDR, otw_pkg::MASK_RESET);
		for (int a = 1; a <= 11; a++)
			rc(8'(a), 8'h00);
		// mode 000: property changes must not commit ahead of the fill
		w(otw_pkg::PROP2_ADDR, 8'hd5, 1'b1);
		w(otw_pkg::PROP1_ADDR, 8'ha6, 1'b0);
		w(otw_pkg::PROP0_ADDR, 8'h3c, 1'b0);
		prop = {7'h55, 8'ha6, 8'h3c};
		rc(otw_pkg::PROP2_ADDR, 8'h55);
		rc(otw_pkg::CURX_ADDR, 8'h00);
		fill(8'h00, 8'h00, 8'h07, 8'h03);
		w(otw_pkg::MASK_ADDR, 8'h20, 1'b1);
		mask = 8'h20;
		w(otw_pkg::PROP2_ADDR, 8'h2a, 1'b1);
		w(otw_pkg::PROP1_ADDR, 8'h59, 1'b0);
		w(otw_pkg::PROP0_ADDR, 8'hc3, 1'b0);
		prop = {7'h2a, 8'h59, 8'hc3};
		fill(8'h02, 8'h01, 8'h05, 8'h02);
		w(otw_pkg::MASK_ADDR, 8'h5b, 1'b1);
		rc(otw_pkg::MASK_ADDR, 8'h5b);
		for (int e = 0; e < 12; e++)
			put(MK[e], 23'(32'h002c3d4e * (e + 1)), NE[e]);
		// cursor parked on the last element must wrap to the first
		w(otw_pkg::CURX_ADDR, 8'h07, 1'b1);
		w(otw_pkg::CURY_ADDR, 8'h03, 1'b0);
		cur = N - 1;
		put(8'hf9, 23'h1b2c3d, 1);
		check_all();
		give_verdict();
	end
endmodule

bind otw_text_window_writer otw_checker #(.COLS(COLS), .ROWS(ROWS),
	.AW(AW)) otw_checker_i (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sub_load_i(sub_load_i),
	.sub_addr_i(sub_addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
	.rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .disp_addr_i(disp_addr_i),
	.disp_data_o(disp_data_o), .fill_busy_o(fill_busy_o));
